// *** pluggable_module_sideband_control_test.sv ***
`default_nettype none
module pluggable_module_sideband_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic clkEn = 1'b1;
    logic selectReq = 1'b0;
    logic resetReq = 1'b0;
    logic lowPowerReq = 1'b0;
    logic cmdValid = 1'b0;
    logic cmdWrite = 1'b0;
    logic [7:0] cmdAddr = 8'h00;
    logic [7:0] cmdWdata = 8'h00;
    logic cmdReady, rspValid, present, irqSeen, lowPowerMode, lanesEnable, initPending;
    logic [7:0] rspData;
    logic [7:0] rd;
    logic lp;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    int n;
    pmsc_if u_pmsc_if ();
    pmsc_device #(.InitCount(4)) u_pmsc_device (.clk(clk), .rstn(rstn), .clkEn(clkEn),
        .link(u_pmsc_if.device), .lowPowerMode(lowPowerMode), .lanesEnable(lanesEnable),
        .initPending(initPending));
    pmsc_host #(.SelectCount(4), .DeselectCount(4)) u_pmsc_host (.clk(clk), .rstn(rstn),
        .clkEn(clkEn), .link(u_pmsc_if.host), .selectReq(selectReq), .resetReq(resetReq),
        .lowPowerReq(lowPowerReq), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
        .cmdAddr(cmdAddr), .cmdWdata(cmdWdata), .cmdReady(cmdReady), .rspData(rspData),
        .rspValid(rspValid), .present(present), .irqSeen(irqSeen));
    pmsc_asserts #(.InitCount(4)) u_pmsc_asserts (.clk(clk), .rstn(rstn),
        .moduleSelectN(u_pmsc_if.moduleSelectN), .moduleResetN(u_pmsc_if.moduleResetN),
        .modulePresentN(u_pmsc_if.modulePresentN), .interruptNOe(u_pmsc_if.interruptNOe),
        .mgmtValid(u_pmsc_if.mgmtValid), .mgmtWrite(u_pmsc_if.mgmtWrite),
        .mgmtAddr(u_pmsc_if.mgmtAddr), .mgmtAck(u_pmsc_if.mgmtAck),
        .mgmtRdata(u_pmsc_if.mgmtRdata));
    always #12.5 clk = ~clk;
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask
    // Request held until the edge that samples ready, then answer awaited
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] r);
        int k;
        logic done;
        k = 0;
        cmdValid <= 1'b1;
        cmdWrite <= w;
        cmdAddr <= a;
        cmdWdata <= d;
        do @(posedge clk); while (cmdReady !== 1'b1 && ++k < 200);
        cmdValid <= 1'b0;
        // A write has no response beat, so its acknowledge on the link ends it
        do
        begin
            @(posedge clk);
            done = w ? u_pmsc_if.mgmtAck : rspValid;
        end
        while (done !== 1'b1 && ++k < 400);
        r = rspData;
        check({7'h00, done}, 8'h01);
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            end_sim();
        end
    end
    initial
    begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        n = 0;
        do @(posedge clk); while (irqSeen !== 1'b1 && ++n < 100);
        check({7'h00, irqSeen}, 8'h01);
        check({7'h00, present}, 8'h01);
        check({7'h00, initPending}, 8'h00);
        check({7'h00, u_pmsc_if.interruptN}, 8'h00);
        selectReq <= 1'b1;
        access(1'b0, pmsc_pkg::StatusAddr, 8'h00, rd);
        check(rd & 8'h01, 8'h00);
        check({7'h00, u_pmsc_if.interruptN}, 8'h01);
        access(1'b0, pmsc_pkg::PowerCtrlAddr, 8'h00, rd);
        check(rd & 8'h03, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            lowPowerReq <= i[2];
            access(1'b1, pmsc_pkg::PowerCtrlAddr, {6'h00, i[1:0]}, rd);
            repeat (4) @(posedge clk);
            lp = i[0] ? i[1] : i[2];
            check({7'h00, lowPowerMode}, {7'h00, lp});
            check({7'h00, lanesEnable}, {7'h00, !lp});
            access(1'b0, pmsc_pkg::PowerCtrlAddr, 8'h00, rd);
            check(rd & 8'h03, {6'h00, i[1:0]});
        end
        access(1'b1, pmsc_pkg::ExtIdAddr, 8'h00, rd);
        access(1'b0, pmsc_pkg::ExtIdAddr, 8'h00, rd);
        check(rd >> pmsc_pkg::PowerClassLsb, 8'h02);
        // A pulse far below the minimum must leave the settings alone
        resetReq <= 1'b1;
        repeat (10) @(posedge clk);
        resetReq <= 1'b0;
        repeat (8) @(posedge clk);
        access(1'b0, pmsc_pkg::PowerCtrlAddr, 8'h00, rd);
        check(rd & 8'h03, 8'h03);
        resetReq <= 1'b1;
        repeat (pmsc_pkg::ResetPulseCycles + 10) @(posedge clk);
        resetReq <= 1'b0;
        @(posedge clk);
        check({7'h00, initPending}, 8'h01);
        n = 0;
        do @(posedge clk); while (initPending !== 1'b0 && ++n < 100);
        check({7'h00, n >= 4 && n < 100}, 8'h01);
        check({7'h00, u_pmsc_if.interruptN}, 8'h00);
        access(1'b0, pmsc_pkg::PowerCtrlAddr, 8'h00, rd);
        check(rd & 8'h03, 8'h00);
        // Override is clear again, so the pin rules; a frozen enable must hold the mode
        clkEn <= 1'b0;
        lowPowerReq <= 1'b0;
        repeat (6) @(posedge clk);
        check({7'h00, lowPowerMode}, 8'h01);
        clkEn <= 1'b1;
        repeat (6) @(posedge clk);
        check({7'h00, lowPowerMode}, 8'h00);
        check({7'h00, lanesEnable}, 8'h01);
        selectReq <= 1'b0;
        lowPowerReq <= 1'b1;
        repeat (8) @(posedge clk);
        check({7'h00, cmdReady}, 8'h00);
        check({7'h00, lowPowerMode}, 8'h01);
        selectReq <= 1'b1;
        repeat (2) @(posedge clk);
        check({7'h00, cmdReady}, 8'h00);
        check({7'h00, irqSeen}, 8'h01);
        access(1'b0, pmsc_pkg::StatusAddr, 8'h00, rd);
        check(rd & 8'h01, 8'h00);
        end_sim();
    end
endmodule
`default_nettype wire

// *** pmsc_asserts.sv ***
`default_nettype none
module pmsc_asserts #(
    parameter int InitCount = pmsc_pkg::InitCycles,
    parameter int ResetPulse = pmsc_pkg::ResetPulseCycles
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic moduleSelectN,
    input wire logic moduleResetN,
    input wire logic modulePresentN,
    input wire logic interruptNOe,
    input wire logic mgmtValid,
    input wire logic mgmtWrite,
    input wire logic [7:0] mgmtAddr,
    input wire logic mgmtAck,
    input wire logic [7:0] mgmtRdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] lowCnt_reg;
    logic statusRd;
    assign statusRd = mgmtValid && !mgmtWrite && mgmtAddr == pmsc_pkg::StatusAddr;
    // Saturates so a very long reset pin low never wraps back into range
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            lowCnt_reg <= 8'h00;
        else if (moduleResetN)
            lowCnt_reg <= 8'h00;
        else if (lowCnt_reg != 8'hff)
            lowCnt_reg <= lowCnt_reg + 8'h01;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    a_present_low: assert property (modulePresentN == 1'b0)
        else $error("presence output not low");
    a_ack_after_req: assert property (mgmtAck |-> $past(mgmtValid))
        else $error("ack without request");
    a_desel_no_ack: assert property (moduleSelectN [*4] |-> !mgmtAck)
        else $error("ack while deselected");
    a_init_wait: assert property ($fell(interruptNOe) |-> $past(moduleResetN, InitCount))
        else $error("completion before init interval");
    a_ready_on_irq: assert property ((statusRd && !interruptNOe) ##1 mgmtAck
        |-> !mgmtRdata[pmsc_pkg::NotReadyBit])
        else $error("not-ready set with completion interrupt");
    a_reset_release: assert property (lowCnt_reg > ResetPulse + 4 |-> interruptNOe)
        else $error("interrupt held during module reset");
    a_no_ack_reset: assert property (lowCnt_reg > ResetPulse + 4 |-> !mgmtAck)
        else $error("ack during module reset");
    a_irq_hold: assert property ((!interruptNOe && moduleResetN && !statusRd)
        |=> !interruptNOe)
        else $error("interrupt dropped without status read");
endmodule
`default_nettype wire

// *** pmsc_device.sv ***
// Design decision made here: the strobed register port.
`default_nettype none
// Contract
// - Answer management only while select is low
// - Undriven select reads as deselected
// - Host waits deselect time before transactions
// - Host waits select time before addressing
// - Undriven reset input reads inactive
// - Long reset low restores all defaults
// - Init interval starts at reset release
// - Host ignores status until reset completes
// - Completion is interrupt with not-ready clear
// - Raise completion interrupt on power-up too
// - Undriven low-power pin requests low power
// - Override and set bits in byte 93
// - Override selects set bit, else pin
// - Override and set bits reset to zero
// - Management and interrupt work in low power
// - High-class module disables lanes in low power
// - Low-class module fully works in both modes
// - Presence output tied low
// - Host reads management on interrupt
// - Interrupt is open-drain, pulls low only; the interface wire interruptN drives it high when no interrupt is pending
module pmsc_device #(
    parameter logic [1:0] PowerClass = 2'h2,
    parameter int InitCount = pmsc_pkg::InitCycles
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clkEn,
    pmsc_if.device link,
    output logic lowPowerMode,
    output logic lanesEnable,
    output logic initPending
);
    localparam int NumPins = 3;
    localparam int NumLanes = 4;
    localparam int SelPin = 0;
    localparam int RstPin = 1;
    localparam int LpPin = 2;
    logic [NumPins-1:0] pinRaw;
    logic [NumPins-1:0] pinSync;
    logic selSync;
    logic rstSync;
    logic lpSync;
    logic lowPower_reg;
    logic laneAllowed;
    logic [NumLanes-1:0] laneOn;
    logic [pmsc_pkg::CntW-1:0] lowCnt_reg;
    logic [pmsc_pkg::CntW-1:0] initCnt_reg;
    logic armed_reg;
    logic notReady_reg;
    logic intPending_reg;
    logic [7:0] powerCtrl_reg;
    logic [7:0] rdata_reg;
    logic ack_reg;
    logic softReset;
    logic selected;
    logic [7:0] statusByte;

    assign pinRaw = {link.lowPowerPin, link.moduleResetN, link.moduleSelectN};

    // Pull-ups modelled by reset-high synchronisers, so no false edge follows reset
    for (genvar p = 0; p < NumPins; p++)
    begin : g_pinSync
        logic meta_reg;
        logic sync_reg;
        always_ff @(posedge clk or negedge rstn)
        begin
            if (!rstn)
            begin
                meta_reg <= 1'b1;
                sync_reg <= 1'b1;
            end
            else if (clkEn)
            begin
                meta_reg <= pinRaw[p];
                sync_reg <= meta_reg;
            end
        end
        assign pinSync[p] = sync_reg;
    end

    assign selSync = pinSync[SelPin];
    assign rstSync = pinSync[RstPin];
    assign lpSync = pinSync[LpPin];

    // Short glitches on the reset pin are ignored
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            lowCnt_reg <= '0;
        else if (clkEn)
        begin
            if (rstSync)
                lowCnt_reg <= '0;
            else if (lowCnt_reg < pmsc_pkg::CntW'(pmsc_pkg::ResetPulseCycles))
                lowCnt_reg <= lowCnt_reg + 1'b1;
        end
    end

    assign softReset = (lowCnt_reg == pmsc_pkg::CntW'(pmsc_pkg::ResetPulseCycles));

    // Init runs after power-up and after each reset release
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            initCnt_reg <= '0;
            armed_reg <= 1'b1;
            notReady_reg <= 1'b1;
        end
        else if (clkEn)
        begin
            if (softReset)
            begin
                initCnt_reg <= '0;
                armed_reg <= 1'b1;
                notReady_reg <= 1'b1;
            end
            else if (armed_reg && rstSync)
            begin
                if (initCnt_reg >= pmsc_pkg::CntW'(InitCount))
                begin
                    armed_reg <= 1'b0;
                    notReady_reg <= 1'b0;
                end
                else
                    initCnt_reg <= initCnt_reg + 1'b1;
            end
        end
    end

    assign selected = !selSync && !softReset;
    assign statusByte = {7'h00, notReady_reg};

    // Interrupt set on completion; cleared by reading status, set wins
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            intPending_reg <= 1'b0;
        else if (clkEn)
        begin
            if (softReset)
                intPending_reg <= 1'b0;
            else if (armed_reg && rstSync && initCnt_reg >= pmsc_pkg::CntW'(InitCount))
                intPending_reg <= 1'b1;
            else if (selected && link.mgmtValid && !link.mgmtWrite &&
                link.mgmtAddr == pmsc_pkg::StatusAddr)
                intPending_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            powerCtrl_reg <= pmsc_pkg::PowerCtrlReset;
        else if (clkEn)
        begin
            if (softReset)
                powerCtrl_reg <= pmsc_pkg::PowerCtrlReset;
            else if (selected && link.mgmtValid && link.mgmtWrite &&
                link.mgmtAddr == pmsc_pkg::PowerCtrlAddr)
                powerCtrl_reg <= link.mgmtWdata;
        end
    end

    // Management stays live in low power mode
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end
        else if (clkEn)
        begin
            ack_reg <= selected && link.mgmtValid;
            if (selected && link.mgmtValid && !link.mgmtWrite)
            begin
                if (link.mgmtAddr == pmsc_pkg::PowerCtrlAddr)
                    rdata_reg <= powerCtrl_reg;
                else if (link.mgmtAddr == pmsc_pkg::ExtIdAddr)
                    rdata_reg <= {PowerClass, 6'h00};
                else if (link.mgmtAddr == pmsc_pkg::StatusAddr)
                    rdata_reg <= statusByte;
                else
                    rdata_reg <= 8'h00;
            end
        end
    end

    // Registered so the mode output never glitches while the override is rewritten
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            lowPower_reg <= 1'b1;
        else if (clkEn)
            lowPower_reg <= powerCtrl_reg[pmsc_pkg::OverrideBit] ?
                powerCtrl_reg[pmsc_pkg::PowerSetBit] : lpSync;
    end

    assign laneAllowed = !notReady_reg && (!lowPower_reg ||
        PowerClass == pmsc_pkg::PowerClassLow);

    // One gate per lane; all move together now, a per-lane policy would slot in here
    for (genvar l = 0; l < NumLanes; l++)
    begin : g_lane
        logic on_reg;
        always_ff @(posedge clk or negedge rstn)
        begin
            if (!rstn)
                on_reg <= 1'b0;
            else if (clkEn)
                on_reg <= laneAllowed;
        end
        assign laneOn[l] = on_reg;
    end

    assign lowPowerMode = lowPower_reg;
    assign lanesEnable = &laneOn;
    assign initPending = notReady_reg;
    assign link.mgmtAck = ack_reg;
    assign link.mgmtRdata = rdata_reg;
    assign link.modulePresentN = 1'b0;
    assign link.interruptNOe = !intPending_reg;
endmodule
`default_nettype wire

// *** pmsc_host.sv ***
`default_nettype none
module pmsc_host #(
    parameter int SelectCount = pmsc_pkg::SelectCycles,
    parameter int DeselectCount = pmsc_pkg::DeselectCycles
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clkEn,
    pmsc_if.host link,
    input wire logic selectReq,
    input wire logic resetReq,
    input wire logic lowPowerReq,
    input wire logic cmdValid,
    input wire logic cmdWrite,
    input wire logic [7:0] cmdAddr,
    input wire logic [7:0] cmdWdata,
    output logic cmdReady,
    output logic [7:0] rspData,
    output logic rspValid,
    output logic present,
    output logic irqSeen
);
    logic presMeta, presSync, intMeta, intSync;
    logic sel_reg;
    logic [pmsc_pkg::CntW-1:0] waitCnt_reg;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            presMeta <= 1'b1;
            presSync <= 1'b1;
            intMeta <= 1'b1;
            intSync <= 1'b1;
        end
        else if (clkEn)
        begin
            presMeta <= link.modulePresentN;
            presSync <= presMeta;
            intMeta <= link.interruptN;
            intSync <= intMeta;
        end
    end

    // Any change of select restarts the settling wait
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sel_reg <= 1'b0;
            waitCnt_reg <= '0;
        end
        else if (clkEn)
        begin
            if (selectReq != sel_reg)
            begin
                sel_reg <= selectReq;
                waitCnt_reg <= selectReq ? pmsc_pkg::CntW'(SelectCount)
                    : pmsc_pkg::CntW'(DeselectCount);
            end
            else if (waitCnt_reg != '0)
                waitCnt_reg <= waitCnt_reg - 1'b1;
        end
    end

    assign cmdReady = sel_reg && waitCnt_reg == '0 && selectReq == sel_reg;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            link.mgmtValid <= 1'b0;
            link.mgmtWrite <= 1'b0;
            link.mgmtAddr <= 8'h00;
            link.mgmtWdata <= 8'h00;
        end
        else if (clkEn)
        begin
            link.mgmtValid <= cmdValid && cmdReady;
            link.mgmtWrite <= cmdWrite;
            link.mgmtAddr <= cmdAddr;
            link.mgmtWdata <= cmdWdata;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rspData <= 8'h00;
            rspValid <= 1'b0;
        end
        else if (clkEn)
        begin
            rspValid <= link.mgmtAck && !link.mgmtWrite;
            if (link.mgmtAck)
                rspData <= link.mgmtRdata;
        end
    end

    assign link.moduleSelectN = !sel_reg;
    assign link.moduleResetN = !resetReq;
    assign link.lowPowerPin = lowPowerReq;
    assign present = !presSync;
    assign irqSeen = !intSync && !presSync;
endmodule
`default_nettype wire

// *** pmsc_if.sv ***
`default_nettype none
interface pmsc_if;
    logic moduleSelectN;
    logic moduleResetN;
    logic lowPowerPin;
    logic modulePresentN;
    logic interruptNOe;
    logic mgmtValid;
    logic mgmtWrite;
    logic [7:0] mgmtAddr;
    logic [7:0] mgmtWdata;
    logic mgmtAck;
    logic [7:0] mgmtRdata;
    wire interruptN = interruptNOe ? 1'b1 : 1'b0;
    modport device (input moduleSelectN, input moduleResetN, input lowPowerPin,
        output modulePresentN, output interruptNOe, input mgmtValid, input mgmtWrite,
        input mgmtAddr, input mgmtWdata, output mgmtAck, output mgmtRdata);
    modport host (output moduleSelectN, output moduleResetN, output lowPowerPin,
        input modulePresentN, input interruptN, output mgmtValid, output mgmtWrite,
        output mgmtAddr, output mgmtWdata, input mgmtAck, input mgmtRdata);
endinterface
`default_nettype wire

// *** pmsc_pkg.sv ***
`default_nettype none
package pmsc_pkg;
    localparam logic [7:0] PowerCtrlAddr = 8'h5d;
    localparam logic [7:0] ExtIdAddr = 8'h81;
    localparam logic [7:0] StatusAddr = 8'h02;
    localparam int OverrideBit = 0;
    localparam int PowerSetBit = 1;
    localparam int NotReadyBit = 0;
    localparam int PowerClassLsb = 6;
    localparam logic [7:0] PowerCtrlReset = 8'h00;
    localparam logic [1:0] PowerClassLow = 2'h0;
    localparam int ClkMhz = 40;
    localparam int ResetPulseNs = 2000;
    localparam int InitNs = 2000;
    localparam int SelectNs = 2000;
    localparam int DeselectNs = 2000;
    localparam int ResetPulseCycles = (ResetPulseNs * ClkMhz + 999) / 1000;
    localparam int InitCycles = (InitNs * ClkMhz) / 1000;
    localparam int SelectCycles = (SelectNs * ClkMhz + 999) / 1000;
    localparam int DeselectCycles = (DeselectNs * ClkMhz + 999) / 1000;
    localparam int CntW = 16;
endpackage
`default_nettype wire
